// [hostport_map.svh]
// Constants of the SRAM-style host port: offsets, timing, strap settings
// Notes on behaviour
// - 16-bit two-way data bus, either byte order
// - 7-bit halfword address reaches registers and FIFOs
// - Read strobe low marks a read
// - Write strobe low marks a write
// - Strobes count only with select low
// - Host write wakes device from low power
// - One interrupt: polarity, sources, buffer selectable
// - Speed strap latched once at reset release
// - Strap 0: 10M half; 1: 100M autoneg
// - FIFO select high routes accesses to FIFOs
// - FIFO select high ignores address bits 7..3
// - Halfwords pair into words; big-endian swaps registers
// - Host reads once before writing; earlier writes dropped
// - Host wakes device by writing byte test register
`ifndef HOSTPORT_MAP_SVH
`define HOSTPORT_MAP_SVH

// Address map (FIFO bounds in bytes, A0 implied zero; byte test as halfword address)
`define HP_FIFO_TOP      8'h40
`define HP_TX_REGION     8'h20
`define HP_BYTE_TEST     7'h32
`define HP_HALF_BIT      0
`define HP_IDX_LSB       1
`define HP_IDX_MSB       6

// Clock and bus timing
`define HP_CLK_NS        40
`define HP_SETUP_NS      40
`define HP_STROBE_NS     320
`define HP_HOLD_NS       120
`define HP_SETUP_CYC     ((`HP_SETUP_NS + `HP_CLK_NS - 1) / `HP_CLK_NS)
`define HP_STROBE_CYC    ((`HP_STROBE_NS + `HP_CLK_NS - 1) / `HP_CLK_NS)
`define HP_HOLD_CYC      ((`HP_HOLD_NS + `HP_CLK_NS - 1) / `HP_CLK_NS)

// Strap sampling delay covers the synchroniser
`define HP_STRAP_DLY     2'h3

// Default duplex for both strap values; idle data bus level
`define HP_DUPLEX_DEF    1'h0
`define HP_IDLE_DATA     16'hFFFF

`endif

// [hostport_pkg.sv]
// Types shared by both ends of the host port
`default_nettype none
package hostport_pkg;

   // Where a host access lands
   typedef enum logic [1:0]
   {
      TGT_RXF = 2'b00,
      TGT_TXF = 2'b01,
      TGT_REG = 2'b10
   } tgt_t;

   // Device power state
   typedef enum logic
   {
      PWR_RUN   = 1'b0,
      PWR_SLEEP = 1'b1
   } pwr_t;

   // Host cycle sequencer
   typedef enum logic [1:0]
   {
      H_IDLE   = 2'b00,
      H_SETUP  = 2'b01,
      H_STROBE = 2'b10,
      H_HOLD   = 2'b11
   } hstate_t;

endpackage
`default_nettype wire

// [host_bus_if.sv]
// Pin-level carrier between the host end and the device end
`timescale 1ns/100ps
`default_nettype none
`include "hostport_map.svh"
interface host_bus_if;
   logic        device_select_low;  // Chip select, active low
   logic        read_strobe_low;    // Read strobe, active low
   logic        write_strobe_low;   // Write strobe, active low
   logic [7:1]  addr;               // Halfword address
   logic        fifo_sel;           // Forces FIFO accesses
   logic        speed_sel;          // Speed strap
   logic [15:0] host_data;          // Host data out
   logic        host_data_oe_b;     // Host drives data, low
   logic [15:0] dev_data;           // Device data out
   logic        dev_data_oe_b;      // Device drives data, low
   logic        irq_out;            // Interrupt pin value
   logic        irq_oe_b;           // Interrupt pin drive, low
   logic [15:0] data_bus;           // Resolved data wire
   logic        irq_line;           // Resolved interrupt wire

   // Wire resolution; undriven lines float to the pull-up level
   assign data_bus = !dev_data_oe_b  ? dev_data :
                     !host_data_oe_b ? host_data : `HP_IDLE_DATA;
   assign irq_line = !irq_oe_b ? irq_out : 1'b1;

   modport device_end
   (
      input  device_select_low, read_strobe_low, write_strobe_low,
      input  addr, fifo_sel, speed_sel, data_bus,
      output dev_data, dev_data_oe_b, irq_out, irq_oe_b
   );

   modport host_end
   (
      output device_select_low, read_strobe_low, write_strobe_low,
      output addr, fifo_sel, speed_sel, host_data, host_data_oe_b,
      input  data_bus, irq_line
   );
endinterface
`default_nettype wire

// [hostport_device.sv]
// Device end of the SRAM-style host port
`timescale 1ns/100ps
`default_nettype none
`include "hostport_map.svh"
module hostport_device
(
   input  wire logic                  clk,             // 25 MHz clock
   input  wire logic                  rst_b,           // Async reset
   host_bus_if.device_end             bus,             // Host pins
   input  wire logic                  big_endian,      // Register order
   input  wire logic                  sleep_req,       // Enter low power
   output logic                       low_power,       // Asleep
   output logic [5:0]                 reg_rd_idx,      // Read word index
   input  wire logic [31:0]           reg_rdata,       // Read word
   output logic                       reg_rd_strobe,   // Read taken
   output logic                       reg_we,          // Write pulse
   output logic [5:0]                 reg_wr_idx,      // Write index
   output logic [31:0]                reg_wdata,       // Write word
   input  wire logic [31:0]           rx_word,         // RX FIFO head
   output logic                       rx_pop,          // RX pop pulse
   output logic                       tx_push,         // TX push pulse
   output logic [31:0]                tx_word,         // TX word
   input  wire logic [7:0]            irq_src,         // Event sources
   input  wire logic [7:0]            irq_en,          // Source enables
   input  wire logic                  irq_pol_high,    // Active high
   input  wire logic                  irq_od,          // Open drain
   output logic                       def_speed_100,   // Default speed
   output logic                       def_full_duplex, // Default duplex
   output logic                       def_autoneg      // Default autoneg
);
   import hostport_pkg::*;

   localparam int PW = 28;

   // Two-flop synchronisers for every pin
   logic [PW-1:0] pin_meta;
   logic [PW-1:0] pin_sync;
   logic          sel_b_s;
   logic          rd_b_s;
   logic          wr_b_s;
   logic          fsel_s;
   logic          strap_s;
   logic [6:0]    addr_s;
   logic [15:0]   data_s;

   // Access tracking
   logic          rd_act;
   logic          wr_act;
   logic          rd_act_q;
   logic          wr_act_q;
   logic          rd_start;
   logic          wr_end;
   logic          drive_q;

   // Write capture and word assembly
   logic [6:0]    wr_addr_cap;
   logic [15:0]   wr_data_cap;
   logic          wr_fsel_cap;
   logic [15:0]   wr_low;
   logic [31:0]   rd_hold;
   logic [31:0]   wr_word;
   logic [31:0]   rd_word;
   tgt_t          rd_tgt;
   tgt_t          wr_tgt;
   logic          rd_upper;
   logic          wr_upper;
   logic          wr_allowed;

   // Power, read-first gate, strap
   pwr_t          pwr;
   logic          read_seen;
   logic [1:0]    strap_cnt;
   logic          strap_done;
   logic          irq_pend;
   logic          irq_assert;

   // Full byte reversal for big-endian register data
   function automatic logic [31:0] order(input logic [31:0] w,
                                         input logic        be,
                                         input tgt_t        t);
      logic [31:0] r;
      r = w;
      if (be && (t == TGT_REG))
      begin
         r = {w[7:0], w[15:8], w[23:16], w[31:24]};
      end
      return r;
   endfunction

   // Target decode shared by read and write paths
   function automatic tgt_t decode(input logic [6:0] a,
                                   input logic       fs,
                                   input logic       wr);
      tgt_t t;
      t = TGT_REG;
      if (fs)
      begin
         t = wr ? TGT_TXF : TGT_RXF;
      end
      else if ({a, 1'b0} < `HP_FIFO_TOP)
      begin
         t = ({a, 1'b0} < `HP_TX_REGION) ? TGT_RXF : TGT_TXF;
      end
      return t;
   endfunction

   // Pin synchronisers; only the second stage is read
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pin_meta <= {PW{1'b1}};
         pin_sync <= {PW{1'b1}};
      end
      else
      begin
         pin_meta <= {bus.device_select_low, bus.read_strobe_low,
                      bus.write_strobe_low, bus.fifo_sel, bus.speed_sel,
                      bus.addr, bus.data_bus};
         pin_sync <= pin_meta;
      end
   end

   assign {sel_b_s, rd_b_s, wr_b_s, fsel_s, strap_s, addr_s, data_s} =
          pin_sync;

   // Strobes qualified by select
   assign rd_act   = !sel_b_s && !rd_b_s;
   assign wr_act   = !sel_b_s && !wr_b_s;
   assign rd_start = rd_act && !rd_act_q;
   assign wr_end   = !wr_act && wr_act_q;

   // Decode and halfword selection
   assign rd_tgt     = decode(addr_s, fsel_s, 1'b0);
   assign wr_tgt     = decode(wr_addr_cap, wr_fsel_cap, 1'b1);
   assign rd_upper   = addr_s[`HP_HALF_BIT];
   assign wr_upper   = wr_addr_cap[`HP_HALF_BIT];
   assign reg_rd_idx = addr_s[`HP_IDX_MSB:`HP_IDX_LSB];
   assign rd_word    = order((rd_tgt == TGT_REG) ? reg_rdata : rx_word,
                             big_endian, rd_tgt);
   assign wr_word    = order({wr_data_cap, wr_low}, big_endian,
                             wr_tgt);

   // Writes before the first read are dropped, and so is the waking one
   assign wr_allowed = read_seen && (pwr == PWR_RUN);

   // Drive only while select and read are low, with data settled
   assign bus.dev_data_oe_b = !(drive_q && rd_act);

   // Edge history
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rd_act_q <= 1'b0;
         wr_act_q <= 1'b0;
         drive_q  <= 1'b0;
      end
      else
      begin
         rd_act_q <= rd_act;
         wr_act_q <= wr_act;
         drive_q  <= rd_act;
      end
   end

   // Capture address and data throughout the strobe
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_addr_cap <= 7'h00;
         wr_data_cap <= 16'h0000;
         wr_fsel_cap <= 1'b0;
      end
      else if (wr_act)
      begin
         wr_addr_cap <= addr_s;
         wr_data_cap <= data_s;
         wr_fsel_cap <= fsel_s;
      end
   end

   // Read path: low half fetches the word, high half reuses it
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rd_hold       <= 32'h0000_0000;
         bus.dev_data  <= 16'h0000;
         reg_rd_strobe <= 1'b0;
         rx_pop        <= 1'b0;
      end
      else
      begin
         reg_rd_strobe <= rd_start && !rd_upper && (rd_tgt == TGT_REG);
         rx_pop        <= rd_start && !rd_upper && (rd_tgt == TGT_RXF);
         if (rd_start && !rd_upper)
         begin
            rd_hold      <= rd_word;
            bus.dev_data <= rd_word[15:0];
         end
         else if (rd_start)
         begin
            bus.dev_data <= rd_hold[31:16];
         end
      end
   end

   // Write path: low half parks, high half commits the word
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_low     <= 16'h0000;
         reg_we     <= 1'b0;
         reg_wr_idx <= 6'h00;
         reg_wdata  <= 32'h0000_0000;
         tx_push    <= 1'b0;
         tx_word    <= 32'h0000_0000;
      end
      else
      begin
         reg_we  <= 1'b0;
         tx_push <= 1'b0;
         if (wr_end && wr_allowed && !wr_upper)
         begin
            wr_low <= wr_data_cap;
         end
         else if (wr_end && wr_allowed)
         begin
            reg_we     <= (wr_tgt == TGT_REG);
            tx_push    <= (wr_tgt == TGT_TXF);
            reg_wr_idx <= wr_addr_cap[`HP_IDX_MSB:`HP_IDX_LSB];
            reg_wdata  <= wr_word;
            tx_word    <= wr_word;
         end
      end
   end

   // Power state; any completed host write wakes, data ignored
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pwr       <= PWR_RUN;
         read_seen <= 1'b0;
      end
      else
      begin
         if (wr_end && (pwr == PWR_SLEEP))
         begin
            pwr       <= PWR_RUN;
            read_seen <= 1'b0;
         end
         else if (sleep_req)
         begin
            pwr       <= PWR_SLEEP;
            read_seen <= 1'b0;
         end
         else if (rd_start)
         begin
            read_seen <= 1'b1;
         end
      end
   end

   assign low_power = (pwr == PWR_SLEEP);

   // Strap taken once the synchroniser holds the real pin level
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         strap_cnt     <= 2'h0;
         strap_done    <= 1'b0;
         def_speed_100 <= 1'b0;
         def_autoneg   <= 1'b0;
      end
      else if (!strap_done)
      begin
         strap_cnt <= strap_cnt + 2'h1;
         if (strap_cnt == `HP_STRAP_DLY)
         begin
            strap_done    <= 1'b1;
            def_speed_100 <= strap_s;
            def_autoneg   <= strap_s;
         end
      end
   end

   assign def_full_duplex = `HP_DUPLEX_DEF;

   // Interrupt pin; open drain only pulls low, so polarity is fixed low
   assign irq_pend   = |(irq_src & irq_en);
   assign irq_assert = irq_od ? 1'b0 : (irq_pol_high ? irq_pend : !irq_pend);

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bus.irq_out  <= 1'b0;
         bus.irq_oe_b <= 1'b1;
      end
      else
      begin
         bus.irq_out  <= irq_assert;
         bus.irq_oe_b <= irq_od ? !irq_pend : 1'b0;
      end
   end

endmodule
`default_nettype wire

// [hostport_host.sv]
// Host end: runs one asynchronous-memory cycle per command
`timescale 1ns/100ps
`default_nettype none
`include "hostport_map.svh"
module hostport_host
(
   input  wire logic                  clk,        // 25 MHz clock
   input  wire logic                  rst_b,      // Async reset
   host_bus_if.host_end               bus,        // Device pins
   input  wire logic                  cmd_valid,  // Command offered
   output logic                       cmd_ready,  // Command taken
   input  wire logic                  cmd_write,  // Write, else read
   input  wire logic [6:0]            cmd_addr,   // Halfword address
   input  wire logic [15:0]           cmd_wdata,  // Write data
   input  wire logic                  fifo_mode,  // Drives FIFO select
   input  wire logic                  strap_100,  // Drives speed strap
   output logic                       rsp_valid,  // Cycle done pulse
   output logic [15:0]                rsp_rdata,  // Read data
   output logic                       irq_level   // Synced IRQ wire
);
   import hostport_pkg::*;

   hstate_t     state;
   hstate_t     next_state;
   logic [3:0]  cnt;
   logic        is_write;
   logic [16:0] in_meta;
   logic [16:0] in_sync;
   logic        phase_done;

   assign cmd_ready  = (state == H_IDLE);
   assign phase_done = (state == H_SETUP  && cnt == 4'(`HP_SETUP_CYC - 1))
                    || (state == H_STROBE && cnt == 4'(`HP_STROBE_CYC - 1))
                    || (state == H_HOLD   && cnt == 4'(`HP_HOLD_CYC - 1));

   // Sequence: setup, strobe, hold with select released
   always_comb
   begin
      next_state = state;
      case (state)
         H_IDLE:   if (cmd_valid) next_state = H_SETUP;
         H_SETUP:  if (phase_done) next_state = H_STROBE;
         H_STROBE: if (phase_done) next_state = H_HOLD;
         H_HOLD:   if (phase_done) next_state = H_IDLE;
         default:  next_state = H_IDLE;
      endcase
   end

   // Pin inputs pass two flops before use
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         in_meta <= 17'h1_FFFF;
         in_sync <= 17'h1_FFFF;
      end
      else
      begin
         in_meta <= {bus.irq_line, bus.data_bus};
         in_sync <= in_meta;
      end
   end

   assign irq_level = in_sync[16];

   // Sequencer, counter and pin drive
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state                 <= H_IDLE;
         cnt                   <= 4'h0;
         is_write              <= 1'b0;
         bus.device_select_low <= 1'b1;
         bus.read_strobe_low   <= 1'b1;
         bus.write_strobe_low  <= 1'b1;
         bus.addr              <= 7'h00;
         bus.host_data         <= 16'h0000;
         bus.host_data_oe_b    <= 1'b1;
         rsp_valid             <= 1'b0;
         rsp_rdata             <= 16'h0000;
      end
      else
      begin
         state     <= next_state;
         cnt       <= (next_state != state) ? 4'h0 : cnt + 4'h1;
         rsp_valid <= 1'b0;
         if (state == H_IDLE && cmd_valid)
         begin
            is_write              <= cmd_write;
            bus.addr              <= cmd_addr;
            bus.host_data         <= cmd_wdata;
            bus.host_data_oe_b    <= !cmd_write;
            bus.device_select_low <= 1'b0;
         end
         if (state == H_SETUP && phase_done)
         begin
            bus.read_strobe_low  <= is_write;
            bus.write_strobe_low <= !is_write;
         end
         if (state == H_STROBE && phase_done)
         begin
            bus.read_strobe_low   <= 1'b1;
            bus.write_strobe_low  <= 1'b1;
            bus.device_select_low <= 1'b1;
            rsp_rdata             <= is_write ? rsp_rdata : in_sync[15:0];
         end
         if (state == H_HOLD && phase_done)
         begin
            bus.host_data_oe_b <= 1'b1;
            rsp_valid          <= 1'b1;
         end
      end
   end

   // Straps are plain levels from the user side
   assign bus.fifo_sel  = fifo_mode;
   assign bus.speed_sel = strap_100;

endmodule
`default_nettype wire

// [hostport_pins_properties.sv]
// Checker on the host port wires between the host and device ends
`timescale 1ns/100ps
`default_nettype none
module hostport_pins_properties
(
   input  wire logic        clk,               // 25 MHz clock
   input  wire logic        rst_b,             // Async reset
   input  wire logic        device_select_low, // Chip select
   input  wire logic        read_strobe_low,   // Read strobe
   input  wire logic        write_strobe_low,  // Write strobe
   input  wire logic [7:1]  addr,              // Halfword address
   input  wire logic [15:0] host_data,         // Host data out
   input  wire logic        host_data_oe_b,    // Host drive, low
   input  wire logic        dev_data_oe_b      // Device drive, low
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // Recent read activity; the device lets go a few cycles late
   wire logic       rd_act = !device_select_low && !read_strobe_low;
   logic      [2:0] rd_hist;
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
         rd_hist <= 3'h0;
      else
         rd_hist <= {rd_hist[1:0], rd_act};

   // Strobe phases of one host cycle
   sequence s_rd_low; (!read_strobe_low)[*8]; endsequence
   sequence s_wr_low; (!write_strobe_low)[*8]; endsequence
   sequence s_strobe_on;
      $fell(read_strobe_low) || $fell(write_strobe_low);
   endsequence

   property p_only_after_read;
      !dev_data_oe_b |-> rd_act || (rd_hist != 3'h0);
   endproperty
   property p_drive_in_read;
      rd_act[*6] |-> !dev_data_oe_b;
   endproperty
   property p_release;
      $rose(read_strobe_low) |-> ##[1:3] dev_data_oe_b;
   endproperty
   property p_no_contention;
      dev_data_oe_b || host_data_oe_b;
   endproperty
   property p_wr_hold;
      !write_strobe_low && $past(!write_strobe_low) |->
         $stable(host_data) && $stable(addr) && !host_data_oe_b;
   endproperty
   property p_strobe_sel;
      !read_strobe_low || !write_strobe_low |-> !device_select_low;
   endproperty
   property p_rd_width;
      $fell(read_strobe_low) |-> s_rd_low ##1 read_strobe_low;
   endproperty
   property p_wr_width;
      $fell(write_strobe_low) |-> s_wr_low ##1 write_strobe_low;
   endproperty
   property p_setup;
      $fell(device_select_low) |-> ##1 s_strobe_on;
   endproperty

   a_only_after_read:
      assert property (p_only_after_read) else $error("Drive outside read");
   a_drive_in_read:
      assert property (p_drive_in_read) else $error("No drive in read");
   a_release:
      assert property (p_release) else $error("Bus not released");
   a_no_contention:
      assert property (p_no_contention) else $error("Both ends drive");
   a_wr_hold:
      assert property (p_wr_hold) else $error("Write data moved");
   a_strobe_sel:
      assert property (p_strobe_sel) else $error("Strobe without select");
   a_rd_width:
      assert property (p_rd_width) else $error("Read strobe width");
   a_wr_width:
      assert property (p_wr_width) else $error("Write strobe width");
   a_setup:
      assert property (p_setup) else $error("Select setup wrong");
endmodule
`default_nettype wire

// [test_sram_style_host_port_pins.sv]
// Testbench joining host end and device end across the pin interface
`timescale 1ns/100ps
`default_nettype none
`include "hostport_map.svh"
module test_sram_style_host_port_pins;
   import hostport_pkg::*;
   // One bus cycle and what it should give
   typedef struct packed {
      logic        wr;
      logic [6:0]  a;
      logic        fs;
      logic        be;
      logic [15:0] d;
      tgt_t        t;
      logic [31:0] exp;
   } row_t;
   logic        clk, rst_b, big_endian, sleep_req, low_power, reg_we;
   logic        rx_pop, tx_push, irq_pol_high, irq_od, reg_rd_strobe;
   logic        def_speed_100, def_full_duplex, def_autoneg, cmd_valid;
   logic        cmd_ready, cmd_write, fifo_mode, strap_100, rsp_valid;
   logic        irq_level;
   logic [5:0]  reg_rd_idx, reg_wr_idx, last_idx;
   logic [31:0] reg_rdata, reg_wdata, rx_word, tx_word, last_word;
   logic [7:0]  irq_src, irq_en;
   logic [6:0]  cmd_addr;
   logic [15:0] cmd_wdata, rsp_rdata;
   tgt_t        last_tgt;
   int          num_errors, total_checks, n_push, cycles, p;
   row_t        rows [16] = '{
      '{0, 7'h00, 0, 0, 16'h0000, TGT_RXF, 32'h0000_5678},
      '{0, 7'h01, 0, 0, 16'h0000, TGT_RXF, 32'h0000_1234},
      '{0, 7'h22, 0, 0, 16'h0000, TGT_REG, 32'h0000_3344},
      '{0, 7'h23, 0, 0, 16'h0000, TGT_REG, 32'h0000_1122},
      '{0, 7'h22, 0, 1, 16'h0000, TGT_REG, 32'h0000_2211},
      '{0, 7'h23, 0, 1, 16'h0000, TGT_REG, 32'h0000_4433},
      '{0, 7'h22, 1, 1, 16'h0000, TGT_RXF, 32'h0000_5678},
      '{0, 7'h23, 1, 1, 16'h0000, TGT_RXF, 32'h0000_1234},
      '{1, 7'h10, 0, 0, 16'hAAAA, TGT_TXF, 32'h0000_0000},
      '{1, 7'h11, 0, 0, 16'hBBBB, TGT_TXF, 32'hBBBB_AAAA},
      '{1, 7'h24, 0, 0, 16'h5566, TGT_REG, 32'h0000_0000},
      '{1, 7'h25, 0, 0, 16'h7788, TGT_REG, 32'h7788_5566},
      '{1, 7'h24, 0, 1, 16'h5566, TGT_REG, 32'h0000_0000},
      '{1, 7'h25, 0, 1, 16'h7788, TGT_REG, 32'h6655_8877},
      '{1, 7'h24, 1, 1, 16'h1111, TGT_TXF, 32'h0000_0000},
      '{1, 7'h25, 1, 1, 16'h2222, TGT_TXF, 32'h2222_1111}};
   // Interrupt cases: source, enable, polarity, open drain, wire level
   logic [4:0]  irq_tab [6] = '{5'h1D, 5'h14, 5'h18, 5'h09, 5'h1E, 5'h0F};

   host_bus_if u_host_bus_if ();
   hostport_device u_hostport_device (.clk(clk), .rst_b(rst_b),
      .bus(u_host_bus_if), .big_endian(big_endian), .sleep_req(sleep_req),
      .low_power(low_power), .reg_rd_idx(reg_rd_idx), .reg_rdata(reg_rdata),
      .reg_rd_strobe(reg_rd_strobe), .reg_we(reg_we),
      .reg_wr_idx(reg_wr_idx), .reg_wdata(reg_wdata), .rx_word(rx_word),
      .rx_pop(rx_pop), .tx_push(tx_push), .tx_word(tx_word),
      .irq_src(irq_src), .irq_en(irq_en), .irq_pol_high(irq_pol_high),
      .irq_od(irq_od), .def_speed_100(def_speed_100),
      .def_full_duplex(def_full_duplex), .def_autoneg(def_autoneg));
   hostport_host u_hostport_host (.clk(clk), .rst_b(rst_b),
      .bus(u_host_bus_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .fifo_mode(fifo_mode), .strap_100(strap_100), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .irq_level(irq_level));
   hostport_pins_properties u_hostport_pins_properties (.clk(clk),
      .rst_b(rst_b), .device_select_low(u_host_bus_if.device_select_low),
      .read_strobe_low(u_host_bus_if.read_strobe_low),
      .write_strobe_low(u_host_bus_if.write_strobe_low),
      .addr(u_host_bus_if.addr), .host_data(u_host_bus_if.host_data),
      .host_data_oe_b(u_host_bus_if.host_data_oe_b),
      .dev_data_oe_b(u_host_bus_if.dev_data_oe_b));

   // 25 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic wrap_up;
      $display("Checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One whole host cycle, long enough for the write commit
   task automatic bus_cycle(input logic wr, input logic [6:0] a,
                            input logic [15:0] d, input logic fs,
                            input logic be);
      int n;
      if (!a[0])
         last_tgt = tgt_t'(2'h3);
      @(negedge clk);
      cmd_write = wr;
      cmd_addr = a;
      cmd_wdata = d;
      fifo_mode = fs;
      big_endian = be;
      cmd_valid = 1'b1;
      for (n = 0; n < 40 && cmd_ready !== 1'b1; n++)
         @(negedge clk);
      @(negedge clk);
      cmd_valid = 1'b0;
      for (n = 0; n < 40 && rsp_valid !== 1'b1; n++)
         @(negedge clk);
      if (n == 40)
         num_errors++;
      repeat (4) @(negedge clk);
   endtask

   // What the device hands to its core side
   always @(posedge clk)
   begin
      if (tx_push === 1'b1 || reg_we === 1'b1)
      begin
         last_tgt = (reg_we === 1'b1) ? TGT_REG : TGT_TXF;
         last_word = (reg_we === 1'b1) ? reg_wdata : tx_word;
         last_idx = reg_wr_idx;
         n_push++;
      end
      if (rx_pop === 1'b1)
         last_tgt = TGT_RXF;
      if (reg_rd_strobe === 1'b1)
      begin
         last_tgt = TGT_REG;
         last_idx = reg_rd_idx;
      end
   end

   // Hang guard, far above the expected run length
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         wrap_up();
      end
   end

   initial
   begin
      {rst_b, big_endian, sleep_req, cmd_valid, cmd_write, fifo_mode} = '0;
      {irq_od, irq_src, irq_en, cmd_addr, cmd_wdata} = '0;
      irq_pol_high = 1'b1;
      strap_100 = 1'b1;
      rx_word = 32'h1234_5678;
      reg_rdata = 32'h1122_3344;
      repeat (2) @(negedge clk);
      check("oe in reset", u_host_bus_if.dev_data_oe_b, 1);
      rst_b = 1'b1;
      repeat (6) @(negedge clk);
      check("speed", def_speed_100, 1);
      check("autoneg", def_autoneg, 1);
      check("duplex", def_full_duplex, 0);
      strap_100 = 1'b0;
      repeat (6) @(negedge clk);
      check("speed held", def_speed_100, 1);
      check("idle bus", u_host_bus_if.data_bus, `HP_IDLE_DATA);
      // Writes ahead of the first read are dropped
      bus_cycle(1, 7'h10, 16'h0001, 0, 0);
      bus_cycle(1, 7'h11, 16'h0002, 0, 0);
      check("early push", n_push, 0);
      for (int i = 0; i < 16; i++)
      begin
         bus_cycle(rows[i].wr, rows[i].a, rows[i].d, rows[i].fs, rows[i].be);
         if (!rows[i].wr)
            check("rdata", rsp_rdata, rows[i].exp);
         if (rows[i].a[0] && rows[i].wr)
            check("word", last_word, rows[i].exp);
         if (rows[i].a[0])
            check("target", last_tgt, rows[i].t);
         if (rows[i].a[0] && rows[i].t == TGT_REG)
            check("index", last_idx, rows[i].a[6:1]);
      end
      // Sleep, wake by a write, then the read gate again
      sleep_req = 1'b1;
      @(negedge clk);
      sleep_req = 1'b0;
      repeat (2) @(negedge clk);
      check("asleep", low_power, 1);
      p = n_push;
      bus_cycle(1, `HP_BYTE_TEST, 16'h0000, 0, 0);
      check("awake", low_power, 0);
      bus_cycle(1, 7'h10, 16'h0003, 0, 0);
      bus_cycle(1, 7'h11, 16'h0004, 0, 0);
      check("gated push", n_push, p);
      bus_cycle(0, 7'h00, 16'h0000, 0, 0);
      bus_cycle(1, 7'h10, 16'h0005, 0, 0);
      bus_cycle(1, 7'h11, 16'h0006, 0, 0);
      check("open push", n_push, p + 1);
      for (int i = 0; i < 6; i++)
      begin
         irq_src = {7'h00, irq_tab[i][4]};
         irq_en = {7'h00, irq_tab[i][3]};
         irq_pol_high = irq_tab[i][2];
         irq_od = irq_tab[i][1];
         repeat (8) @(negedge clk);
         check("irq", irq_level, irq_tab[i][0]);
      end
      // Second reset with the strap low
      rst_b = 1'b0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      repeat (6) @(negedge clk);
      check("speed 10", def_speed_100, 0);
      check("autoneg off", def_autoneg, 0);
      check("duplex 10", def_full_duplex, 0);
      wrap_up();
   end
endmodule
`default_nettype wire
